// ---- rtl/icm_pkg.sv ----
// Constants for the default interrupt channel map and dispatch logic.
// Assumes a single system clock and that every source line is a level
// synchronous to it.
package icm_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned NUM_CH = 128;
  localparam int unsigned CH_W   = 7;

  // Vector table: word zero is the phantom entry, channel n sits at n + 1.
  localparam logic [CH_W-1:0] PHANTOM_WORD = 7'h00;
  localparam logic [CH_W-1:0] VEC_OFFSET   = 7'h01;
  localparam logic [CH_W-1:0] LAST_VEC_CH  = 7'h7e;

  // ****************************************************************
  // Default channels of the named sources
  // ****************************************************************
  localparam logic [CH_W-1:0] CH_LIN_L1       = 7'h1b; // 27
  localparam logic [CH_W-1:0] CH_ADC1_SWG2    = 7'h1c; // 28
  localparam logic [CH_W-1:0] CH_ADC1_MAGCMP  = 7'h1f; // 31
  localparam logic [CH_W-1:0] CH_NET_L1       = 7'h20; // 32
  localparam logic [CH_W-1:0] CH_BSP3_L0      = 7'h25; // 37
  localparam logic [CH_W-1:0] CH_BSP3_L1      = 7'h26; // 38
  localparam logic [CH_W-1:0] CH_EXT_MEM      = 7'h29; // 41
  localparam logic [CH_W-1:0] CH_CAN3_L0      = 7'h2d; // 45
  localparam logic [CH_W-1:0] CH_NTU_STATUS   = 7'h30; // 48
  localparam logic [CH_W-1:0] CH_ADC2_EVT     = 7'h32; // 50
  localparam logic [CH_W-1:0] CH_ADC2_SWG1    = 7'h33; // 51
  localparam logic [CH_W-1:0] CH_NET_TIMER0   = 7'h34; // 52
  localparam logic [CH_W-1:0] CH_CAN3_L1      = 7'h37; // 55
  localparam logic [CH_W-1:0] CH_ADC2_SWG2    = 7'h39; // 57
  localparam logic [CH_W-1:0] CH_NTU_ERROR    = 7'h3a; // 58
  localparam logic [CH_W-1:0] CH_ADC2_MAGCMP  = 7'h3b; // 59
  localparam logic [CH_W-1:0] CH_CAN3_IF3     = 7'h3c; // 60
  localparam logic [CH_W-1:0] CH_NET_TIMER1   = 7'h3e; // 62
  localparam logic [CH_W-1:0] CH_HET2_L0      = 7'h3f; // 63
  localparam logic [CH_W-1:0] CH_HET2_L1      = 7'h49; // 73
  localparam logic [CH_W-1:0] CH_PWM_BASE     = 7'h58; // 88
  localparam int unsigned     NUM_PWM         = 7;

  // ****************************************************************
  // Reserved channel ranges (no source by default)
  // ****************************************************************
  localparam int unsigned RSV_A    = 1;
  localparam int unsigned RSV_B    = 36;
  localparam int unsigned RSV_C    = 43;
  localparam int unsigned RSV_D_LO = 67;
  localparam int unsigned RSV_D_HI = 72;
  localparam int unsigned RSV_E    = 84;
  localparam int unsigned RSV_F_LO = 86;
  localparam int unsigned RSV_F_HI = 87;
  localparam int unsigned RSV_G_LO = 112;
  localparam int unsigned RSV_G_HI = 127;

endpackage : icm_pkg

// ---- rtl/icm_channel_map.sv ----
// Default source-to-channel routing, remap table and fixed-priority
// dispatch toward the core, plus the external memory wait-rise flag.
// Assumes all inputs are synchronous to mclk_i; the core reads the
// registered winner every cycle and acknowledges by other means.
//
// Notes on behaviour
// [R1] Lowest pending channel index among 0 to 126 always wins.
// [R2] Vector word zero is the phantom entry only.
// [R3] Only channels zero to 126 get dispatched.
// [R4] Channel n vector is table word n+1.
// [R5] First converter group two 28, compare 31.
// [R6] Second converter 50, 51, 57, 59 defaults.
// [R7] Network controller 32, 52, 62 defaults.
// [R8] Transfer unit status 48, error 58.
// [R9] Third CAN 45, 55, 60 defaults.
// [R10] Third buffered serial port 37 and 38.
// [R11] LIN serial port level one on 27.
// [R12] Second timer 63 and 73 defaults.
// [R13] PWM k event 90+2k, trip next channel.
// [R14] Wait input rising edge raises wait-rise flag.
// [R15] Wait-rise flag already set after power-up.
// [R16] Memory using wait must drive it continuously.
// [R17] 128 channels, each with enable and priority.
// [R18] Software can remap each channel's source.
// [R19] Reserved channels stay quiet unless remapped.
`timescale 1ns/1ps
`default_nettype none

module icm_channel_map #(
  parameter int unsigned NUM_CH = icm_pkg::NUM_CH,
  parameter int unsigned CH_W   = icm_pkg::CH_W
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // Named peripheral sources
  input  wire logic              lin_l1_i,
  input  wire logic              adc_unit_one_swg2_i,
  input  wire logic              adc_unit_one_magcmp_i,
  input  wire logic              adc_unit_two_evt_i,
  input  wire logic              adc_unit_two_swg1_i,
  input  wire logic              adc_unit_two_swg2_i,
  input  wire logic              adc_unit_two_magcmp_i,
  input  wire logic              net_l1_i,
  input  wire logic              network_timer_zero_i,
  input  wire logic              network_timer_one_i,
  input  wire logic              network_transfer_unit_status_i,
  input  wire logic              network_transfer_unit_error_i,
  input  wire logic              can_ctrl_three_l0_i,
  input  wire logic              can_ctrl_three_l1_i,
  input  wire logic              can_ctrl_three_if3_i,
  input  wire logic              buffered_serial_port_three_l0_i,
  input  wire logic              buffered_serial_port_three_l1_i,
  input  wire logic              high_end_timer_two_l0_i,
  input  wire logic              high_end_timer_two_l1_i,
  input  wire logic [6:0]        pwm_event_irq_i,
  input  wire logic [6:0]        pwm_trip_zone_irq_i,
  // Remaining sources, bit index equals default channel
  input  wire logic [NUM_CH-1:0] other_req_i,
  // External memory wait pin and its flag control
  input  wire logic              ext_memory_wait_low_i,
  input  wire logic              ext_memory_irq_clr_i,
  output logic                   ext_memory_irq_o,
  // Channel enables and remap write port
  input  wire logic [NUM_CH-1:0] chan_enable_i,
  input  wire logic              map_we_i,
  input  wire logic [CH_W-1:0]   map_chan_i,
  input  wire logic [CH_W-1:0]   map_src_i,
  // Dispatch toward the core
  output logic                   irq_o,
  output logic [CH_W-1:0]        irq_chan_o,
  output logic [CH_W-1:0]        vec_word_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // True for a source index that has nothing wired to it.
  function automatic logic is_reserved(input int unsigned c);
    is_reserved = (c == icm_pkg::RSV_A) || (c == icm_pkg::RSV_B) ||
                  (c == icm_pkg::RSV_C) || (c == icm_pkg::RSV_E) ||
                  ((c >= icm_pkg::RSV_D_LO) && (c <= icm_pkg::RSV_D_HI)) ||
                  ((c >= icm_pkg::RSV_F_LO) && (c <= icm_pkg::RSV_F_HI)) ||
                  ((c >= icm_pkg::RSV_G_LO) && (c <= icm_pkg::RSV_G_HI));
  endfunction : is_reserved

  // ****************************************************************
  // Wait-rise detection
  // ****************************************************************
  logic wait_prev_r;
  logic wait_prev_nxt;
  logic wait_flag_r;
  logic wait_flag_nxt;

  // The previous sample resets low, so a pin held high by its pull-up
  // reads as a rising edge on the first edge after reset. That flags the
  // condition at power-up, which software ignores if the pin is unused.
  always_comb begin
    wait_prev_nxt = ext_memory_wait_low_i;
    wait_flag_nxt = wait_flag_r;
    if (ext_memory_irq_clr_i) begin
      wait_flag_nxt = 1'b0;
    end
    // An edge in the clear cycle still sets the flag.
    if (ext_memory_wait_low_i && !wait_prev_r) begin
      wait_flag_nxt = 1'b1; // [R14] [R15]
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_prev_r <= 1'b0; // [R15]
      wait_flag_r <= 1'b0;
    end else begin
      wait_prev_r <= wait_prev_nxt;
      wait_flag_r <= wait_flag_nxt;
    end
  end

  assign ext_memory_irq_o = wait_flag_r;

  // ****************************************************************
  // Default source vector
  // ****************************************************************
  logic [NUM_CH-1:0] src_vec;

  // Named sources override the generic vector at their default slots;
  // reserved slots are forced low so they never request by themselves.
  always_comb begin
    src_vec = other_req_i;
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      if (is_reserved(c)) begin
        src_vec[c] = 1'b0; // [R19]
      end
    end
    src_vec[icm_pkg::CH_LIN_L1]      = lin_l1_i;                        // [R11]
    src_vec[icm_pkg::CH_ADC1_SWG2]   = adc_unit_one_swg2_i;             // [R5]
    src_vec[icm_pkg::CH_ADC1_MAGCMP] = adc_unit_one_magcmp_i;           // [R5]
    src_vec[icm_pkg::CH_ADC2_EVT]    = adc_unit_two_evt_i;              // [R6]
    src_vec[icm_pkg::CH_ADC2_SWG1]   = adc_unit_two_swg1_i;             // [R6]
    src_vec[icm_pkg::CH_ADC2_SWG2]   = adc_unit_two_swg2_i;             // [R6]
    src_vec[icm_pkg::CH_ADC2_MAGCMP] = adc_unit_two_magcmp_i;           // [R6]
    src_vec[icm_pkg::CH_NET_L1]      = net_l1_i;                        // [R7]
    src_vec[icm_pkg::CH_NET_TIMER0]  = network_timer_zero_i;            // [R7]
    src_vec[icm_pkg::CH_NET_TIMER1]  = network_timer_one_i;             // [R7]
    src_vec[icm_pkg::CH_NTU_STATUS]  = network_transfer_unit_status_i;  // [R8]
    src_vec[icm_pkg::CH_NTU_ERROR]   = network_transfer_unit_error_i;   // [R8]
    src_vec[icm_pkg::CH_CAN3_L0]     = can_ctrl_three_l0_i;             // [R9]
    src_vec[icm_pkg::CH_CAN3_L1]     = can_ctrl_three_l1_i;             // [R9]
    src_vec[icm_pkg::CH_CAN3_IF3]    = can_ctrl_three_if3_i;            // [R9]
    src_vec[icm_pkg::CH_BSP3_L0]     = buffered_serial_port_three_l0_i; // [R10]
    src_vec[icm_pkg::CH_BSP3_L1]     = buffered_serial_port_three_l1_i; // [R10]
    src_vec[icm_pkg::CH_HET2_L0]     = high_end_timer_two_l0_i;         // [R12]
    src_vec[icm_pkg::CH_HET2_L1]     = high_end_timer_two_l1_i;         // [R12]
    src_vec[icm_pkg::CH_EXT_MEM]     = wait_flag_r;
    for (int unsigned k = 0; k < icm_pkg::NUM_PWM; k++) begin
      src_vec[icm_pkg::CH_PWM_BASE + CH_W'(2 * k + 2)] = pwm_event_irq_i[k];     // [R13]
      src_vec[icm_pkg::CH_PWM_BASE + CH_W'(2 * k + 3)] = pwm_trip_zone_irq_i[k]; // [R13]
    end
  end

  // ****************************************************************
  // Remap table
  // ****************************************************************
  logic [CH_W-1:0] map_r   [NUM_CH];
  logic [CH_W-1:0] map_nxt [NUM_CH];

  // Each channel names the source it listens to; reset gives identity,
  // which is the default routing above.
  always_comb begin
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      map_nxt[c] = map_r[c];
    end
    if (map_we_i) begin
      map_nxt[map_chan_i] = map_src_i; // [R18]
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int unsigned c = 0; c < NUM_CH; c++) begin
        map_r[c] <= CH_W'(c);
      end
    end else begin
      for (int unsigned c = 0; c < NUM_CH; c++) begin
        map_r[c] <= map_nxt[c];
      end
    end
  end

  // ****************************************************************
  // Pending and fixed-priority selection
  // ****************************************************************
  logic [NUM_CH-1:0] pending;
  logic              win_valid;
  logic [CH_W-1:0]   win_chan;

  // The top channel is never offered: it has no vector slot, so a
  // request there would only ever dispatch the phantom entry.
  always_comb begin
    win_valid = 1'b0;
    win_chan  = '0;
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      pending[c] = src_vec[map_r[c]] & chan_enable_i[c]; // [R17]
    end
    for (int c = int'(icm_pkg::LAST_VEC_CH); c >= 0; c--) begin // [R3]
      if (pending[c]) begin
        win_valid = 1'b1; // [R1]
        win_chan  = CH_W'(c);
      end
    end
  end

  // ****************************************************************
  // Dispatch registers
  // ****************************************************************
  logic            irq_r;
  logic            irq_nxt;
  logic [CH_W-1:0] chan_r;
  logic [CH_W-1:0] chan_nxt;
  logic [CH_W-1:0] vec_r;
  logic [CH_W-1:0] vec_nxt;

  // With nothing pending the vector reads the phantom word, so a core
  // that samples late lands on the phantom routine, never a channel.
  always_comb begin
    irq_nxt  = win_valid;
    chan_nxt = win_chan;
    vec_nxt  = icm_pkg::PHANTOM_WORD; // [R2]
    if (win_valid) begin
      vec_nxt = win_chan + icm_pkg::VEC_OFFSET; // [R4]
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_r  <= 1'b0;
      chan_r <= '0;
      vec_r  <= '0;
    end else begin
      irq_r  <= irq_nxt;
      chan_r <= chan_nxt;
      vec_r  <= vec_nxt;
    end
  end

  assign irq_o      = irq_r;
  assign irq_chan_o = chan_r;
  assign vec_word_o = vec_r;

endmodule : icm_channel_map

`default_nettype wire

// ---- verification/icm_map_props.sv ----
// Checker for the channel map: dispatch outputs and the wait-rise flag.
// Assumes it is bound to icm_channel_map and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module icm_map_props #(
  parameter int unsigned NUM_CH = 128,
  parameter int unsigned CH_W   = 7
) (
  // Clock, reset and watched inputs
  input wire logic              mclk_i,
  input wire logic              resetn_i,
  input wire logic              lin_l1_i,
  input wire logic              adc_unit_one_swg2_i,
  input wire logic [6:0]        pwm_trip_zone_irq_i,
  input wire logic              ext_memory_wait_low_i,
  input wire logic              ext_memory_irq_clr_i,
  input wire logic [NUM_CH-1:0] chan_enable_i,
  // Watched outputs
  input wire logic              ext_memory_irq_o,
  input wire logic              irq_o,
  input wire logic [CH_W-1:0]   irq_chan_o,
  input wire logic [CH_W-1:0]   vec_word_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ****************************************************************
  // Dispatch
  // ****************************************************************
  vec_offset_a: assert property (irq_o |-> vec_word_o == irq_chan_o + 7'h01)
    else $error("vector word is not channel plus one");
  phantom_idle_a: assert property (!irq_o
      |-> vec_word_o == 7'h00 && irq_chan_o == 7'h00)
    else $error("idle dispatch does not point at the phantom word");
  top_chan_a: assert property (irq_o |-> irq_chan_o != 7'h7f)
    else $error("highest channel was dispatched");
  no_enable_a: assert property (chan_enable_i == '0 |=> !irq_o)
    else $error("request with every channel disabled");
  lin_wins_a: assert property (lin_l1_i && chan_enable_i[27]
      |=> irq_o && irq_chan_o <= 7'h1b)
    else $error("a higher channel beat channel 27");
  adc_swg2_a: assert property (adc_unit_one_swg2_i && chan_enable_i[28]
      |=> irq_o && irq_chan_o <= 7'h1c)
    else $error("converter group two request not on channel 28");
  trip_last_a: assert property (pwm_trip_zone_irq_i[6] && chan_enable_i[103]
      |=> irq_o && irq_chan_o <= 7'h67)
    else $error("last trip request not on channel 103");
  // ****************************************************************
  // Wait-rise flag
  // ****************************************************************
  // The rise needs two samples, so it is a sequence of its own.
  sequence pin_rise_s;
    !ext_memory_wait_low_i ##1 ext_memory_wait_low_i;
  endsequence
  wait_rise_a: assert property (pin_rise_s |=> ext_memory_irq_o)
    else $error("wait rise did not set the flag");
  flag_hold_a: assert property (ext_memory_irq_o && !ext_memory_irq_clr_i
      |=> ext_memory_irq_o)
    else $error("wait flag dropped without a clear");
  // Before the first sample after reset the pin history is unknown, so skip that edge.
  flag_clear_a: assert property (ext_memory_irq_clr_i && $past(resetn_i)
      && !$rose(ext_memory_wait_low_i) |=> !ext_memory_irq_o)
    else $error("wait flag survived a clear");
endmodule : icm_map_props
`default_nettype wire

// ---- verification/icm_core_model.sv ----
// Behavioural core that fetches a service routine id from its vector table.
// Assumes the dispatch outputs of the channel map feed it directly.
`timescale 1ns/1ps
`default_nettype none
module icm_core_model (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  // Dispatch from the controller
  input wire logic       irq_i,
  input wire logic [6:0] vec_word_i,
  // Routine that was entered
  output var logic [7:0] isr_id_o
);
  logic [7:0] vtab [128];
  // Software fills the table: word zero is the phantom routine, ff.
  initial begin
    vtab[0] = 8'hff;
    for (int w = 1; w < 128; w++) vtab[w] = 8'(w - 1);
  end
  // The core enters the routine named by the vector word while a request pends.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      isr_id_o <= 8'hff;
    end else if (irq_i) begin
      isr_id_o <= vtab[vec_word_i];
    end
  end
endmodule : icm_core_model
`default_nettype wire

// ---- verification/icm_channel_map_tb.sv ----
// Self-checking bench for the channel map with a behavioural core model.
// Assumes the package and design are compiled first; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module icm_channel_map_tb;
  // Bench state; src bits 0..18 are the named lines, 19.. the PWM pairs.
  logic         mclk_i = 1'b0;
  logic         resetn_i = 1'b0;
  logic [32:0]  src = '0;
  logic [6:0]   pe;
  logic [6:0]   pt;
  logic [127:0] oth = '0;
  logic [127:0] en = '0;
  logic         pin = 1'b1;
  logic         clr = 1'b0;
  logic         we = 1'b0;
  logic [6:0]   mch = '0;
  logic [6:0]   msrc = '0;
  logic         irq;
  logic         flag;
  logic [6:0]   chan;
  logic [6:0]   vec;
  logic [7:0]   isr;
  int           fail_count = 0;
  int           compares = 0;
  localparam int TBL[19] = '{27, 28, 31, 50, 51, 57, 59, 32, 52, 62, 48, 58, 45, 55, 60, 37,
                             38, 63, 73};
  // Clock at 25 ns.
  initial forever #12.5 mclk_i = ~mclk_i;
  // PWM event k sits on src 19+2k and its trip line on the bit after.
  always_comb for (int k = 0; k < 7; k++) begin
    pe[k] = src[19+2*k];
    pt[k] = src[20+2*k];
  end
  icm_channel_map DUT (.mclk_i, .resetn_i, .lin_l1_i(src[0]), .adc_unit_one_swg2_i(src[1]),
    .adc_unit_one_magcmp_i(src[2]), .adc_unit_two_evt_i(src[3]), .adc_unit_two_swg1_i(src[4]),
    .adc_unit_two_swg2_i(src[5]), .adc_unit_two_magcmp_i(src[6]), .net_l1_i(src[7]),
    .network_timer_zero_i(src[8]), .network_timer_one_i(src[9]),
    .network_transfer_unit_status_i(src[10]), .network_transfer_unit_error_i(src[11]),
    .can_ctrl_three_l0_i(src[12]), .can_ctrl_three_l1_i(src[13]), .can_ctrl_three_if3_i(src[14]),
    .buffered_serial_port_three_l0_i(src[15]), .buffered_serial_port_three_l1_i(src[16]),
    .high_end_timer_two_l0_i(src[17]), .high_end_timer_two_l1_i(src[18]), .pwm_event_irq_i(pe),
    .pwm_trip_zone_irq_i(pt), .other_req_i(oth), .ext_memory_wait_low_i(pin),
    .ext_memory_irq_clr_i(clr), .ext_memory_irq_o(flag), .chan_enable_i(en), .map_we_i(we),
    .map_chan_i(mch), .map_src_i(msrc), .irq_o(irq), .irq_chan_o(chan), .vec_word_o(vec));
  icm_core_model core (.mclk_i, .resetn_i, .irq_i(irq), .vec_word_i(vec), .isr_id_o(isr));
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // Let n rising edges pass, then sample on the falling edge where outputs are settled.
  task automatic wt(int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : wt
  function automatic int ch_of(int i);
    return (i < 19) ? TBL[i] : 71 + i;
  endfunction : ch_of
  task automatic t_single;
    for (int i = 0; i < 33; i++) begin
      @(posedge mclk_i);
      src <= 33'h1 << i;
      en <= '1;
      wt(1);
      chk("chan", {1'b0, chan}, 8'(ch_of(i)));
      chk("vec", {1'b0, vec}, 8'(ch_of(i) + 1));
      wt(1);
      chk("isr", isr, 8'(ch_of(i)));
    end
  endtask : t_single
  // All 33 src lines pend; the winner is retired one at a time, lowest first.
  task automatic t_prio;
    logic [127:0] e;
    int c;
    e = '0;
    for (int i = 0; i < 33; i++) e[ch_of(i)] = 1'b1;
    @(posedge mclk_i);
    src <= '1;
    en <= e;
    for (int k = 0; k < 33; k++) begin
      wt(1);
      c = 0;
      for (int j = 127; j >= 0; j--) if (e[j]) c = j;
      chk("prio", {1'b0, chan}, 8'(c));
      e[c] = 1'b0;
      @(posedge mclk_i);
      en <= e;
    end
    wt(1);
    chk("idle vec", {1'b0, vec}, 8'h00);
  endtask : t_prio
  // Generic lines pend everywhere but only reserved channels are enabled.
  task automatic t_reserved;
    @(posedge mclk_i);
    src <= '0;
    oth <= '1;
    // Enables exactly 1, 36, 43, 67-72, 84, 86-87 and 112-127, 128 bits in all.
    en <= {16'hffff, 24'h0, 4'b1101, 11'h0, 6'h3f, 23'h0, 1'b1, 6'h0, 1'b1, 34'h0, 2'b10};
    wt(1);
    chk("rsv irq", {7'h0, irq}, 8'h00);
  endtask : t_reserved
  task automatic t_remap;
    @(posedge mclk_i);
    src <= 33'h2;
    oth <= '0;
    en <= {1'b1, 127'h0};
    we <= 1'b1;
    mch <= 7'h7f;
    msrc <= 7'h1c;
    @(posedge mclk_i);
    mch <= 7'h7e;
    @(posedge mclk_i);
    we <= 1'b0;
    wt(1);
    chk("top irq", {7'h0, irq}, 8'h00);
    @(posedge mclk_i);
    en <= {2'b11, 126'h0};
    wt(1);
    chk("remap chan", {1'b0, chan}, 8'h7e);
    chk("remap vec", {1'b0, vec}, 8'h7f);
    @(posedge mclk_i);
    we <= 1'b1;
    mch <= 7'h01;
    en <= {2'b11, 124'h0, 2'b10};
    @(posedge mclk_i);
    we <= 1'b0;
    wt(1);
    chk("remap low", {1'b0, chan}, 8'h01);
  endtask : t_remap
  // The pin is always driven by the bench, as a memory using it must.
  task automatic t_wait;
    @(posedge mclk_i);
    src <= '0;
    en <= 128'h1 << 41;
    pin <= 1'b0;
    wt(1);
    chk("flag low", {7'h0, flag}, 8'h00);
    @(posedge mclk_i);
    pin <= 1'b1;
    wt(1);
    chk("flag rise", {7'h0, flag}, 8'h01);
    wt(1);
    chk("flag chan", {1'b0, chan}, 8'h29);
    @(posedge mclk_i);
    clr <= 1'b1;
    pin <= 1'b0;
    @(posedge mclk_i);
    pin <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
    @(negedge mclk_i);
    chk("set wins", {7'h0, flag}, 8'h01);
  endtask : t_wait
  task automatic close_out;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Main sequence: the pin idles high through reset, so the flag comes up on the first edge after reset.
  initial begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    wt(2);
    chk("power flag", {7'h0, flag}, 8'h01);
    @(posedge mclk_i);
    clr <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
    t_single();
    t_prio();
    t_reserved();
    t_remap();
    t_wait();
    close_out();
  end
  // The run needs a few hundred cycles; cut it off well beyond that.
  initial begin
    #125000;
    fail_count++;
    close_out();
  end
endmodule : icm_channel_map_tb
bind icm_channel_map icm_map_props #(.NUM_CH(NUM_CH), .CH_W(CH_W)) u_props (.mclk_i,
  .resetn_i, .lin_l1_i, .adc_unit_one_swg2_i, .pwm_trip_zone_irq_i, .ext_memory_wait_low_i,
  .ext_memory_irq_clr_i, .chan_enable_i, .ext_memory_irq_o, .irq_o, .irq_chan_o, .vec_word_o);
`default_nettype wire
